// [hw/gqw_pkg.sv]
// Purpose: Shared constants and types for the pin qualifier and wake block
// Assumes: One 40 MHz system clock; 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned words
`default_nettype none

package gqw_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Structure
	localparam int          GROUP_PINS = 8;
	localparam int          GROUPS     = 2;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0]  OFF_QPRD   = 8'h00;
	localparam logic [7:0]  OFF_QSEL   = 8'h04;
	localparam logic [7:0]  OFF_LPM    = 8'h08;
	localparam logic [7:0]  OFF_STAT   = 8'h0C;

	// Low-power control field positions
	localparam int          LPM_ENTER  = 0;
	localparam int          LPM_STBY   = 1;
	localparam int          LPM_FSLP   = 2;
	localparam int          LPM_SQEN   = 3;
	localparam int          LPM_SQC    = 8;
	localparam int          LPM_IEN    = 16;

	// Status field positions
	localparam int          STAT_LPM   = 16;
	localparam int          STAT_RES   = 17;

	// Reset values
	localparam logic [15:0] RST_QPRD   = 16'h0000;
	localparam logic [15:0] RST_QSEL   = 16'h0000;
	localparam logic [31:0] RST_LPM    = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Timing counts, in cycles of the clock named
	localparam logic [2:0]  BLANK_OSC       = 3'h4;
	localparam logic [6:0]  STBY_RAW_OSC    = 7'h03;
	localparam logic [6:0]  STBY_QUAL_BASE  = 7'h02;
	localparam logic [10:0] RESUME_ACT_CYC  = 11'd20;
	localparam logic [10:0] RESUME_SLP_CYC  = 11'd1050;

	// Bus responses
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	// Wake sequencer states
	typedef enum logic [3:0] {
		ST_RUN    = 4'b0001,
		ST_BLANK  = 4'b0010,
		ST_LPM    = 4'b0100,
		ST_RESUME = 4'b1000
	} gqw_state_t;

endpackage

`default_nettype wire

// [hw/gqw_qual_if.sv]
// Purpose: Carries one group of eight pins between control and qualifier
// Assumes: Driven in the system clock domain
// Notes:   One shared period per group, one sample select per pin
`default_nettype none

interface gqw_qual_if;
	logic [7:0] period;
	logic [7:0] six_sel;
	logic [7:0] pins;
	logic [7:0] qual;
	modport ctrl      (output period, output six_sel, output pins, input qual);
	modport qual_side (input period, input six_sel, input pins, output qual);
endinterface

`default_nettype wire

// [hw/gqw_qual.sv]
// Purpose: Sampling divider and 3/6 sample qualifier for one group of eight pins
// Assumes: Pins already synchronous to i_clk
// Notes:   Qualified level resets low
`default_nettype none

module gqw_qual (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	gqw_qual_if.qual_side    q
);

	// All kept samples agree: three newest, or all six
	function automatic logic f_agree(input logic [5:0] h, input logic six);
		if (six)
			return (h == 6'h00) || (h == 6'h3F);
		return (h[2:0] == 3'h0) || (h[2:0] == 3'h7);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [8:0]  cnt_q, cnt_d;
	logic        strobe;
	logic [5:0]  hist_q [8], hist_d [8];
	logic [7:0]  qual_d;

	// Divider: >= guards against a period lowered mid-count
	always_comb begin
		strobe = (q.period == 8'h00) || (cnt_q >= ({q.period, 1'b0} - 9'h001)); // R1 R2 R3
		cnt_d  = strobe ? 9'h000 : cnt_q + 9'h001;
		qual_d = q.qual;
		for (int i = 0; i < 8; i++) begin
			hist_d[i] = strobe ? {hist_q[i][4:0], q.pins[i]} : hist_q[i];
			// Level moves only on full agreement, so glitches die here
			if (strobe && f_agree(hist_d[i], q.six_sel[i])) // R5 R6 R7 R8 R17
				qual_d[i] = hist_d[i][0];
		end
	end

	// Registers only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q  <= 9'h000;
			q.qual <= 8'h00;
			for (int i = 0; i < 8; i++)
				hist_q[i] <= 6'h00;
		end else begin
			cnt_q  <= cnt_d;
			q.qual <= qual_d;
			for (int i = 0; i < 8; i++)
				hist_q[i] <= hist_d[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_r1;
		@(posedge i_clk) disable iff (!i_rst_n)
		(q.period == 8'h00) |-> strobe;
	endproperty
	a_r1: assert property (p_r1) else $error("sample missed at zero period"); // R1

	property p_r2;
		@(posedge i_clk) disable iff (!i_rst_n)
		(strobe && q.period == 8'h02 ##1 q.period == 8'h02) |->
			(!strobe || q.period != 8'h02) [*3] ##1 (strobe || q.period != 8'h02);
	endproperty
	a_r2: assert property (p_r2) else $error("sample spacing not 2n"); // R2

	property p_r6;
		@(posedge i_clk) disable iff (!i_rst_n)
		($changed(q.qual[0]) && !$past(q.six_sel[0])) |->
			$past(hist_d[0][2:0]) == {3{q.qual[0]}};
	endproperty
	a_r6: assert property (p_r6) else $error("three sample change without agreement"); // R6

	property p_r7;
		@(posedge i_clk) disable iff (!i_rst_n)
		($changed(q.qual[1]) && $past(q.six_sel[1])) |->
			$past(hist_d[1]) == {6{q.qual[1]}};
	endproperty
	a_r7: assert property (p_r7) else $error("six sample change without agreement"); // R7

	property p_r8;
		@(posedge i_clk) disable iff (!i_rst_n)
		(strobe && !f_agree(hist_d[0], q.six_sel[0])) |=> $stable(q.qual[0]);
	endproperty
	a_r8: assert property (p_r8) else $error("glitch passed the qualifier"); // R8

	property p_r17;
		@(posedge i_clk) disable iff (!i_rst_n)
		(q.qual != $past(q.qual)) |-> $past(strobe);
	endproperty
	a_r17: assert property (p_r17) else $error("level moved off a sample"); // R17

	c_six: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(q.qual[1]) && q.six_sel[1] && q.period != 8'h00);

endmodule

`default_nettype wire

// [hw/gqw_top.sv]
// Purpose: GPIO input qualifier for sixteen pins plus low-power wake sequencer
// Assumes: All inputs synchronous to i_clk; oscillator clock sampled as a level
// Notes:   AXI4-Lite slave, two writes (second held until the first response) and one read outstanding at most
//
// Functional notes
// R1: Zero period field samples every pin on every system clock.
// R2: Nonzero period n samples once every 2n system clocks.
// R3: Period field spans zero to 0xFF, eight bits.
// R4: One period setting serves each group of eight pins.
// R5: Per-pin select chooses three or six samples.
// R6: Three samples span two sampling periods.
// R7: Six samples span five sampling periods.
// R8: Glitches not stable across all samples are ignored.
// R9: Driver holds levels at least two clocks, or window plus period plus one.
// R10: IDLE wake lasts two clocks, or five plus window when qualified. The code wakes from IDLE on one clock of any enabled source, unqualified.
// R11: IDLE exits on enabled interrupt, watchdog, non-maskable or reset pin.
// R12: Wake source waits four oscillator cycles after IDLE entry.
// R13: Resume within 20 clocks from RAM or active flash.
// R14: Resume within 1050 clocks when flash sleeps.
// R15: Latency ends at next instruction start; interrupt service adds more.
// R16: STANDBY wake lasts three oscillator cycles, or two plus six-bit count.
// R17: Qualified value changes only when all samples agree, else holds.
`default_nettype none

module gqw_top (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [15:0] i_pins,
	input  wire logic        i_osc_clk,
	input  wire logic [7:0]  i_irq,
	input  wire logic        i_wdog_irq,
	input  wire logic        i_ext_nmi,
	input  wire logic        i_ext_reset,
	output logic      [15:0] o_qual,
	output logic             o_lpm_active,
	output logic             o_resume,
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready
);

	// Merge write data into a word under byte strobes
	function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// Address names a mapped register
	function automatic logic f_mapped(input logic [7:0] a);
		return (a == gqw_pkg::OFF_QPRD) || (a == gqw_pkg::OFF_QSEL) ||
			(a == gqw_pkg::OFF_LPM) || (a == gqw_pkg::OFF_STAT);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bus state
	logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
	logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [7:0]  awa_q, awa_d, ara_q, ara_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0]  ws_q, ws_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic        arr_q, arr_d, rv_q, rv_d;
	logic        wr_fire;

	// Registers
	logic [15:0] qprd_q, qprd_d, qsel_q, qsel_d;
	logic [31:0] lpm_q, lpm_d;
	logic        enter_req;
	logic [15:0] qual_w;

	// Sequencer
	gqw_pkg::gqw_state_t st_q, st_d;
	logic [2:0]  blank_q, blank_d;
	logic [6:0]  swid_q, swid_d;
	logic [10:0] res_q, res_d;
	logic        osc_q, osc_edge, wake_any, stby_wake, res_pls_d, res_pls_q;
	logic [6:0]  stby_need;

	////////////////////////////////////////////////////////////////////////////
	// Qualifier groups; one period byte per group of eight
	gqw_qual_if qif [gqw_pkg::GROUPS] ();

	for (genvar g = 0; g < gqw_pkg::GROUPS; g++) begin : g_grp
		assign qif[g].period  = qprd_q[8*g +: 8]; // R4
		assign qif[g].six_sel = qsel_q[8*g +: 8]; // R5
		assign qif[g].pins    = i_pins[8*g +: 8];
		assign qual_w[8*g +: 8] = qif[g].qual;
		gqw_qual u_qual (
			.i_clk   (i_clk),
			.i_rst_n (i_rst_n),
			.q       (qif[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order
	always_comb begin
		aw_got_d = aw_got_q | (i_s_axi_awvalid & awr_q);
		awa_d    = (i_s_axi_awvalid & awr_q) ? i_s_axi_awaddr : awa_q;
		w_got_d  = w_got_q | (i_s_axi_wvalid & wr_q);
		wd_d     = (i_s_axi_wvalid & wr_q) ? i_s_axi_wdata : wd_q;
		ws_d     = (i_s_axi_wvalid & wr_q) ? i_s_axi_wstrb : ws_q;
		wr_fire  = aw_got_q & w_got_q & ~bv_q;
		bv_d     = (bv_q & ~i_s_axi_bready) | wr_fire;
		br_d     = wr_fire ? (f_mapped(awa_q) ? gqw_pkg::RESP_OKAY : gqw_pkg::RESP_SLV) : br_q;
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
		end
		awr_d = ~aw_got_d;
		wr_d  = ~w_got_d;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awr_q    <= 1'b0;
			wr_q     <= 1'b0;
			bv_q     <= 1'b0;
			br_q     <= gqw_pkg::RESP_OKAY;
			awa_q    <= 8'h00;
			wd_q     <= 32'h0000_0000;
			ws_q     <= 4'h0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q  <= w_got_d;
			awr_q    <= awr_d;
			wr_q     <= wr_d;
			bv_q     <= bv_d;
			br_q     <= br_d;
			awa_q    <= awa_d;
			wd_q     <= wd_d;
			ws_q     <= ws_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file; the entry bit is a strobe and never stored
	always_comb begin
		qprd_d    = qprd_q;
		qsel_d    = qsel_q;
		lpm_d     = lpm_q;
		enter_req = 1'b0;
		if (wr_fire) begin
			unique case (awa_q)
				gqw_pkg::OFF_QPRD: qprd_d = 16'(f_merge({16'h0000, qprd_q}, wd_q, ws_q)); // R3
				gqw_pkg::OFF_QSEL: qsel_d = 16'(f_merge({16'h0000, qsel_q}, wd_q, ws_q));
				gqw_pkg::OFF_LPM: begin
					lpm_d     = f_merge(lpm_q, wd_q, ws_q);
					enter_req = lpm_d[gqw_pkg::LPM_ENTER];
					lpm_d[gqw_pkg::LPM_ENTER] = 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qprd_q <= gqw_pkg::RST_QPRD;
			qsel_q <= gqw_pkg::RST_QSEL;
			lpm_q  <= gqw_pkg::RST_LPM;
		end else begin
			qprd_q <= qprd_d;
			qsel_q <= qsel_d;
			lpm_q  <= lpm_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel; unmapped offsets answer SLVERR with zero data
	always_comb begin
		arr_d = ~rv_q & ~(i_s_axi_arvalid & arr_q);
		rv_d  = (rv_q & ~i_s_axi_rready) | (i_s_axi_arvalid & arr_q);
		ara_d = (i_s_axi_arvalid & arr_q) ? i_s_axi_araddr : ara_q;
		rd_d  = rd_q;
		rr_d  = rr_q;
		if (i_s_axi_arvalid & arr_q) begin
			rr_d = f_mapped(i_s_axi_araddr) ? gqw_pkg::RESP_OKAY : gqw_pkg::RESP_SLV;
			unique case (i_s_axi_araddr)
				gqw_pkg::OFF_QPRD: rd_d = {16'h0000, qprd_q};
				gqw_pkg::OFF_QSEL: rd_d = {16'h0000, qsel_q};
				gqw_pkg::OFF_LPM:  rd_d = lpm_q;
				gqw_pkg::OFF_STAT: rd_d = {14'h0000, st_q == gqw_pkg::ST_RESUME,
					o_lpm_active, o_qual};
				default:           rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arr_q <= 1'b0;
			rv_q  <= 1'b0;
			ara_q <= 8'h00;
			rd_q  <= 32'h0000_0000;
			rr_q  <= gqw_pkg::RESP_OKAY;
		end else begin
			arr_q <= arr_d;
			rv_q  <= rv_d;
			ara_q <= ara_d;
			rd_q  <= rd_d;
			rr_q  <= rr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake sequencer. Wakes during blanking are ignored, since the source
	// must not act before four oscillator cycles have passed.
	always_comb begin
		osc_edge  = i_osc_clk & ~osc_q;
		wake_any  = |(i_irq & lpm_q[gqw_pkg::LPM_IEN +: 8]) | i_wdog_irq |
			i_ext_nmi | i_ext_reset; // R11
		stby_need = lpm_q[gqw_pkg::LPM_SQEN] ?
			gqw_pkg::STBY_QUAL_BASE + {1'b0, lpm_q[gqw_pkg::LPM_SQC +: 6]} :
			gqw_pkg::STBY_RAW_OSC;
		stby_wake = wake_any && (swid_q >= stby_need);
		st_d      = st_q;
		blank_d   = blank_q;
		// Saturate rather than wrap, so a long wake never restarts the count
		swid_d    = wake_any ? swid_q + {6'h00, osc_edge & (swid_q != 7'h7F)} : 7'h00;
		res_d     = res_q;
		res_pls_d = 1'b0;
		unique case (st_q)
			gqw_pkg::ST_RUN: begin
				blank_d = 3'h0;
				if (enter_req)
					st_d = gqw_pkg::ST_BLANK;
			end
			gqw_pkg::ST_BLANK: begin
				blank_d = blank_q + {2'h0, osc_edge};
				if (blank_d == gqw_pkg::BLANK_OSC)
					st_d = gqw_pkg::ST_LPM;
			end
			gqw_pkg::ST_LPM: begin
				res_d = lpm_q[gqw_pkg::LPM_FSLP] ? gqw_pkg::RESUME_SLP_CYC - 11'd1 :
					gqw_pkg::RESUME_ACT_CYC - 11'd1; // R13 R14
				if (lpm_q[gqw_pkg::LPM_STBY] ? stby_wake : wake_any) // R11
					st_d = gqw_pkg::ST_RESUME;
			end
			gqw_pkg::ST_RESUME: begin
				// Pulse marks the next instruction start, not interrupt entry
				res_d = res_q - 11'd1;
				if (res_q == 11'd0) begin
					res_pls_d = 1'b1; // R15
					st_d      = gqw_pkg::ST_RUN;
				end
			end
			default: st_d = gqw_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q      <= gqw_pkg::ST_RUN;
			blank_q   <= 3'h0;
			swid_q    <= 7'h00;
			res_q     <= 11'd0;
			osc_q     <= 1'b0;
			res_pls_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			blank_q   <= blank_d;
			swid_q    <= swid_d;
			res_q     <= res_d;
			osc_q     <= i_osc_clk;
			res_pls_q <= res_pls_d;
		end
	end

	// Output flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_qual       <= 16'h0000;
			o_lpm_active <= 1'b0;
		end else begin
			o_qual       <= qual_w;
			o_lpm_active <= (st_d != gqw_pkg::ST_RUN);
		end
	end

	assign o_resume        = res_pls_q;
	assign o_s_axi_awready = awr_q;
	assign o_s_axi_wready  = wr_q;
	assign o_s_axi_bvalid  = bv_q;
	assign o_s_axi_bresp   = br_q;
	assign o_s_axi_arready = arr_q;
	assign o_s_axi_rvalid  = rv_q;
	assign o_s_axi_rdata   = rd_q;
	assign o_s_axi_rresp   = rr_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks; age counts cycles spent resuming
	logic [11:0] age_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			age_q <= 12'h000;
		else
			age_q <= (st_q == gqw_pkg::ST_RESUME) ? age_q + 12'h001 : 12'h000;
	end

	property p_r11;
		@(posedge i_clk) disable iff (!i_rst_n)
		(st_q == gqw_pkg::ST_LPM && !lpm_q[gqw_pkg::LPM_STBY] && wake_any) |=>
			st_q == gqw_pkg::ST_RESUME;
	endproperty
	a_r11: assert property (p_r11) else $error("idle wake not taken"); // R11

	property p_r13;
		@(posedge i_clk) disable iff (!i_rst_n)
		(st_q == gqw_pkg::ST_RESUME && !lpm_q[gqw_pkg::LPM_FSLP]) |-> age_q < 12'd20;
	endproperty
	a_r13: assert property (p_r13) else $error("resume past 20 cycles"); // R13

	property p_r14;
		@(posedge i_clk) disable iff (!i_rst_n)
		(st_q == gqw_pkg::ST_RESUME) |-> age_q < 12'd1050;
	endproperty
	a_r14: assert property (p_r14) else $error("resume past 1050 cycles"); // R14

	property p_r15;
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(st_q == gqw_pkg::ST_RESUME) |-> o_resume ##1 !o_resume;
	endproperty
	a_r15: assert property (p_r15) else $error("resume pulse misplaced"); // R15

	property p_r3;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_fire && awa_q == gqw_pkg::OFF_QPRD && ws_q[0]) |=> qprd_q[7:0] == $past(wd_q[7:0]);
	endproperty
	a_r3: assert property (p_r3) else $error("period field not stored"); // R3

	c_idle: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_resume);
	c_stby: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		st_q == gqw_pkg::ST_LPM && lpm_q[gqw_pkg::LPM_STBY] && stby_wake);
	c_fslp: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		age_q == 12'd1049);

endmodule

`default_nettype wire

// [verif/gqw_pin_drv.sv]
// Purpose: Outside world driving the pins and the wake lines
// Assumes: Levels change by non-blocking assignment after a rising edge
// Notes:   Wake lines are eight interrupts, then watchdog, NMI and reset pin
`default_nettype none

module gqw_pin_drv (
	input  wire logic        i_clk,
	output var  logic [15:0] o_pins,
	output var  logic [10:0] o_line
);
	timeunit 1ns;
	timeprecision 1ps;

	// Everything idles low so no wake is pending at entry
	initial begin
		o_pins = 16'h0000;
		o_line = 11'h000;
	end

	////////////////////////////////////////////////////////////////////////
	// The caller holds a level for whole cycles; the width decides glitch or edge
	task automatic set_pins(input logic [15:0] m, input logic lvl);
		@(posedge i_clk);
		o_pins <= lvl ? (o_pins | m) : (o_pins & ~m);
	endtask

	// A pulse shorter than the window models a glitch
	task automatic pulse(input logic [15:0] m, input int w);
		set_pins(m, 1'b1);
		repeat (w) @(posedge i_clk);
		o_pins <= o_pins & ~m;
	endtask

	// Wake is held until resume is seen or the caller's limit runs out
	task automatic set_line(input logic [10:0] m, input logic lvl);
		@(posedge i_clk);
		o_line <= lvl ? (o_line | m) : (o_line & ~m);
	endtask
endmodule

`default_nettype wire

// [verif/gqw_top_bench.sv]
// Purpose: Self-checking bench for the pin qualifier and the wake sequencer
// Assumes: Bus and wake latencies as the design's bus contract gives them
// Notes:   Qualifier latencies are judged against a measured base pin
`default_nettype none

module gqw_top_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int          CEIL = 8000;
	localparam logic [31:0] EN   = 32'h1 << gqw_pkg::LPM_ENTER;
	localparam logic [31:0] IE0  = 32'h1 << gqw_pkg::LPM_IEN;
	localparam logic [31:0] SB   = 32'h1 << gqw_pkg::LPM_STBY;
	localparam logic [31:0] FS   = 32'h1 << gqw_pkg::LPM_FSLP;
	localparam logic [31:0] SQ4  = (32'h1 << gqw_pkg::LPM_SQEN) | (32'h4 << gqw_pkg::LPM_SQC);

	logic        i_clk, i_rst_n, osc, awv, wv, bry, arv, rry;
	logic        awr, wr, bv, arr, rv, lpm, res;
	logic [7:0]  awa, ara;
	logic [3:0]  wst;
	logic [31:0] wd, rd;
	logic [1:0]  br, rr;
	logic [15:0] pins, qual;
	logic [10:0] line;
	int          n_fail, n_compared, cyc;
	int          lat [16];

	gqw_top DUT (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(pins), .i_osc_clk(osc),
		.i_irq(line[7:0]), .i_wdog_irq(line[8]), .i_ext_nmi(line[9]), .i_ext_reset(line[10]),
		.o_qual(qual), .o_lpm_active(lpm), .o_resume(res),
		.i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(wst), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
		.o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
		.i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
		.o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry)
	);
	gqw_pin_drv drv (.i_clk(i_clk), .o_pins(pins), .o_line(line));

	// Oscillator is four system cycles long and unrelated in phase
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	initial begin
		osc = 1'b0;
		#13;
		forever #50 osc = ~osc;
	end

	// A hang counts as a mismatch and goes straight to the report
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == CEIL) begin
			n_fail = n_fail + 1;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_rng(input int g, input int lo, input int hi);
		n_compared++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("FAIL at %0t: got %h expected %h to %h", $time, g, lo, hi);
		end
	endtask

	// Address and data offered together, each dropped at its own taking
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge i_clk);
			if (awv && awr) begin
				awv <= 1'b0;
				ad = 1'b1;
			end
			if (wv && wr) begin
				wv <= 1'b0;
				dd = 1'b1;
			end
		end
		do @(posedge i_clk); while (bv !== 1'b1);
		r = br;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge i_clk); while (!(arv && arr));
		arv <= 1'b0;
		do @(posedge i_clk); while (rv !== 1'b1);
		d = rd;
		r = rr;
	endtask

	// Cycles from driving a mask to each pin's qualified change
	task automatic measure(input logic [15:0] m, input logic lvl);
		drv.set_pins(m, lvl);
		foreach (lat[i]) lat[i] = -1;
		for (int n = 0; n < 60; n++) begin
			@(posedge i_clk);
			for (int i = 0; i < 16; i++)
				if (m[i] && lat[i] < 0 && qual[i] === lvl) lat[i] = n;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axr(gqw_pkg::OFF_QPRD, d, r);
		chk(d, 32'(gqw_pkg::RST_QPRD));
		axr(gqw_pkg::OFF_QSEL, d, r);
		chk(d, 32'(gqw_pkg::RST_QSEL));
		axr(gqw_pkg::OFF_LPM, d, r);
		chk(d, gqw_pkg::RST_LPM);
		axw(gqw_pkg::OFF_QPRD, 32'h0000_FFFF, r);
		chk(32'(r), 32'(gqw_pkg::RESP_OKAY));
		axr(gqw_pkg::OFF_QPRD, d, r);
		chk(d, 32'h0000_FFFF);
		chk(32'(r), 32'(gqw_pkg::RESP_OKAY));
		// Only the low byte lane may change the stored word
		wst <= 4'h1;
		axw(gqw_pkg::OFF_QPRD, 32'h0000_0000, r);
		wst <= 4'hF;
		axr(gqw_pkg::OFF_QPRD, d, r);
		chk(d, 32'h0000_FF00);
		axw(8'h10, 32'h0000_FFFF, r);
		chk(32'(r), 32'(gqw_pkg::RESP_SLV));
		axr(8'h10, d, r);
		chk(32'(r), 32'(gqw_pkg::RESP_SLV));
		$display("register test done");
	endtask

	// Pin 8 is the base: group 1 every cycle, three samples
	task automatic t_qual;
		logic [1:0] r;
		axw(gqw_pkg::OFF_QPRD, 32'h0000_0002, r);
		axw(gqw_pkg::OFF_QSEL, 32'h0000_0202, r);
		for (int v = 1; v >= 0; v--) begin
			measure(16'h0303, v[0]);
			chk_rng(lat[8], 2, 6);
			chk_rng(lat[9], lat[8] + 3, lat[8] + 3);
			chk_rng(lat[0], lat[8] + 6, lat[8] + 9);
			chk_rng(lat[1], lat[8] + 18, lat[8] + 21);
		end
		drv.pulse(16'h0100, 2);
		drv.pulse(16'h0200, 5);
		drv.pulse(16'h0001, 4);
		repeat (30) @(posedge i_clk);
		chk(32'(qual), 32'h0);
		$display("qualifier test done");
	endtask

	// Enter, wait out blanking, raise one source; hi of 0 expects no wake
	task automatic t_wake(input logic [31:0] lw, input int s, input int hold,
		input int lo, input int hi);
		logic [1:0] r;
		int         n;
		axw(gqw_pkg::OFF_LPM, lw, r);
		repeat (20) @(posedge i_clk);
		chk(32'(lpm), 32'h1);
		drv.set_line(11'h001 << s, 1'b1);
		for (n = 0; n < hold && res !== 1'b1; n++) @(posedge i_clk);
		drv.set_line(11'h001 << s, 1'b0);
		if (hi == 0) begin
			repeat (8) @(posedge i_clk);
			chk(32'(lpm), 32'h1);
		end else begin
			chk_rng(n, lo, hi);
			chk(32'(res), 32'h0);
			chk(32'(lpm), 32'h0);
		end
		$display("wake test done");
	endtask

	task automatic results;
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence: reset held three cycles, first request one edge later
	initial begin
		int src [4] = '{0, 8, 9, 10};
		i_rst_n = 1'b0;
		{awv, wv, bry, arv, rry} = 5'h00;
		{awa, ara, wd} = 48'h0;
		wst = 4'hF;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		t_regs();
		t_qual();
		t_wake(EN | IE0, 1, 30, 0, 0);
		foreach (src[i]) t_wake(EN | IE0, src[i], 40, 20, 26);
		t_wake(EN | IE0 | FS, 0, 1200, 1050, 1056);
		t_wake(EN | SB, 8, 6, 0, 0);
		t_wake(EN | SB, 8, 60, 22, 40);
		t_wake(EN | SB | SQ4, 8, 18, 0, 0);
		t_wake(EN | SB | SQ4, 8, 80, 30, 55);
		results();
	end
endmodule

`default_nettype wire
